// *** rtl/usbrx_defs.vh ***
// Constants of the receive endpoint control block: offsets, fields, resets.
// Assumes a 6-bit register address bus and 8-bit data, as on the device.
`ifndef USBRX_DEFS_VH
`define USBRX_DEFS_VH
// Register offsets of the three receive pipes.
`define USBRX_OFS_DATA1    6'h2D
`define USBRX_OFS_STAT1    6'h2E
`define USBRX_OFS_CMD1     6'h2F
`define USBRX_OFS_DATA2    6'h35
`define USBRX_OFS_STAT2    6'h36
`define USBRX_OFS_CMD2     6'h37
`define USBRX_OFS_DATA3    6'h3D
`define USBRX_OFS_STAT3    6'h3E
`define USBRX_OFS_CMD3     6'h3F
// FIFO warning event register offset.
`define USBRX_OFS_FIFO_WARNING_EVENT_REGISTER     6'h10
// Command register field positions.
`define USBRX_CMD_EN       0
`define USBRX_CMD_IGN      2
`define USBRX_CMD_FLUSH    3
`define USBRX_CMD_WL_LO    5
`define USBRX_CMD_WL_HI    6
// Status register field positions.
`define USBRX_ST_CNT_HI    3
`define USBRX_ST_LAST      4
`define USBRX_ST_TOGGLE    5
`define USBRX_ST_SETUP     6
`define USBRX_ST_ERR       7
// Warning event register: receive warning bits sit at 4 + pipe index.
`define USBRX_FIFO_WARNING_EVENT_REGISTER_RX_LO   4
// Reset values.
`define USBRX_CMD_RST      8'h00
`define USBRX_STAT_RST     8'h00
// Saturation value of the reported byte count.
`define USBRX_CNT_SAT      4'hF
// Free-byte limits of the warning field codes.
`define USBRX_WL_1         8'h04
`define USBRX_WL_2         8'h08
`define USBRX_WL_3         8'h10
`endif

// *** rtl/usbrx_fifo.v ***
// Synchronous FIFO with valid and ready on both sides and a flush input.
// Assumes one clock and an active-low asynchronous reset already released.
`timescale 1ns/1ps
module usbrx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             rst_n,
  // Flush drops all contents and resets both pointers.
  input  wire             flush,
  // Fill side.
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side.
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  // Fill level.
  output wire [AW:0]      count
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Storage entries.
  reg [AW-1:0]    wr_q;              // Write pointer.
  reg [AW-1:0]    rd_q;              // Read pointer.
  reg [AW:0]      cnt_q;             // Number of stored words.
  wire            push;              // Word taken in.
  wire            pop;               // Word handed out.
  integer         i;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers and count; flush overrides any transfer in the same cycle.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // Storage write; data needs no reset.
  always @(posedge clk) begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (push && wr_q == i[AW-1:0]) begin
        mem_q[i] <= in_data;
      end
    end
  end
endmodule // usbrx_fifo

// *** rtl/usbrx_ctrl.v ***
// Receive endpoint control for the three receive pipes of a USB function.
// Assumes a packet decoder in front that delivers tokens, payload bytes
// (identifier and CRC16 already split off by it, only payload presented)
// and packet end with good or bad status, all synchronous to I_CLK_SYS.
//
// Operation
// - Receive enable clears per OUT packet; firmware re-arms.
// - SETUP accepted regardless of receive enable.
// - Back-to-back SETUP: drop data, still ACK.
// - Otherwise unacceptable SETUP gets no handshake.
// - Ignore-setup bit disregards all SETUP tokens.
// - Flush empties FIFO, idles pipe, resets pointers.
// - Flush waits until current reception ends.
// - Few free bytes sets receive warning flag.
// - Warning field: off, 4, 8, 16 free bytes.
// - Only payload bytes reach the data register.
// - Command and data register for each pipe.
// - Status reports byte count, saturating at fifteen.
// - Media error flagged in status; firmware flushes. Second status copy never sets the error bit.
// - Two status copies: zero-length then SETUP.
`timescale 1ns/1ps
`include "usbrx_defs.vh"
module usbrx_ctrl #(
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset.
  input  wire       I_CLK_SYS,
  input  wire       I_RESET_N,
  // Register access port, one access per strobe.
  input  wire [5:0] I_ADDR,
  input  wire       I_WR,
  input  wire       I_RD,
  input  wire [7:0] I_WDATA,
  output reg  [7:0] O_RDATA,
  // Packet side: token start, payload byte, packet end.
  input  wire       I_TOK,
  input  wire [1:0] I_TOK_PIPE,
  input  wire       I_TOK_SETUP,
  input  wire       I_STALL,
  input  wire       I_BYTE_VLD,
  input  wire [7:0] I_BYTE,
  input  wire       I_PKT_END,
  input  wire       I_PKT_OK,
  input  wire       I_PKT_TOGGLE,
  // Handshake answer to the host.
  output reg        O_ACK,
  output reg        O_NAK,
  // Receive-warning flags of the three pipes.
  output reg  [2:0] O_RX_WARN
);
  // Receive state, one-hot.
  localparam [2:0] ST_IDLE = 3'b001; // Waiting for a token.
  localparam [2:0] ST_RECV = 3'b010; // Storing payload.
  localparam [2:0] ST_DROP = 3'b100; // Swallowing a packet.

  reg        rs1_q;                   // Reset synchroniser, first stage.
  reg        rst_n;                   // Synchronised reset.
  reg  [2:0] st_q;                    // Receive state.
  reg  [1:0] cur_q;                   // Pipe of the current packet.
  reg        cur_setup_q;             // Current packet is a SETUP.
  reg  [2:0] en_q;                    // Receive enable per pipe.
  reg  [2:0] ign_q;                   // Ignore-setup per pipe.
  reg  [2:0] flreq_q;                 // Pending flush per pipe.
  reg  [5:0] wl_q;                    // Warning limit fields, 2 bits each.
  reg  [2:0] lastsetup_q;             // Last token to the pipe was SETUP.
  reg  [7:0] stat_q [0:2];            // Primary status copy.
  reg  [7:0] stat2_q [0:2];           // Second status copy.
  reg  [2:0] st2v_q;                  // Second copy holds a status.
  reg  [2:0] ovf_q;                   // Payload overflowed during packet.
  wire [2:0] fl;                      // Flush acting now.
  wire [2:0] in_rdy;                  // FIFO can take a byte.
  wire [2:0] out_vld;                 // FIFO holds a byte.
  wire [7:0] out_dat [0:2];           // Oldest byte per FIFO.
  wire [AW:0] cnt [0:2];              // Fill level per FIFO.
  wire [2:0] push;                    // Byte into FIFO.
  wire [2:0] pop;                     // Byte read by firmware.
  wire [2:0] hit_d;                   // Data register addressed.
  wire [2:0] hit_s;                   // Status register addressed.
  wire [2:0] hit_c;                   // Command register addressed.
  wire [2:0] busy;                    // Pipe receiving now.
  wire [2:0] warn_d;                  // Next value of the warning flags.
  wire       tok_ok;                  // Token names one of our pipes.

  assign tok_ok = I_TOK && (I_TOK_PIPE != 2'd3);

  // Reset release through two flip-flops.
  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // Per-pipe FIFO, decode and warning comparison.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pipe
      wire [7:0] free;   // Free bytes in the FIFO.
      assign busy[g]  = (st_q == ST_RECV) && (cur_q == g);
      // A flush pends until the pipe stops receiving.
      assign fl[g]    = flreq_q[g] && !busy[g];
      assign push[g]  = busy[g] && I_BYTE_VLD;
      assign hit_d[g] = (I_ADDR == `USBRX_OFS_DATA1 + g * 6'h08);
      assign hit_s[g] = (I_ADDR == `USBRX_OFS_STAT1 + g * 6'h08);
      assign hit_c[g] = (I_ADDR == `USBRX_OFS_CMD1 + g * 6'h08);
      assign pop[g]   = I_RD && hit_d[g] && out_vld[g];
      assign free     = DEPTH[7:0] - {{(7-AW){1'b0}}, cnt[g]};
      usbrx_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .clk       (I_CLK_SYS),
        .rst_n     (rst_n),
        .flush     (fl[g]),
        .in_valid  (push[g]),
        .in_ready  (in_rdy[g]),
        .in_data   (I_BYTE),
        .out_valid (out_vld[g]),
        .out_ready (pop[g]),
        .out_data  (out_dat[g]),
        .count     (cnt[g])
      );
      // Warning flag follows the free-byte comparison; code 00 is off.
      assign warn_d[g] =
        (wl_q[2*g+1 -: 2] == 2'b01) ? (free <= `USBRX_WL_1) :
        (wl_q[2*g+1 -: 2] == 2'b10) ? (free <= `USBRX_WL_2) :
        (wl_q[2*g+1 -: 2] == 2'b11) ? (free <= `USBRX_WL_3) :
        1'b0;
    end
  endgenerate

  // All three warning flags are held in one process, one driver each.
  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      O_RX_WARN <= 3'b000;
    end else begin
      O_RX_WARN <= warn_d;
    end
  end

  // Packet receive state machine and handshake.
  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= ST_IDLE;
      cur_q       <= 2'd0;
      cur_setup_q <= 1'b0;
      O_ACK       <= 1'b0;
      O_NAK       <= 1'b0;
    end else begin
      O_ACK <= 1'b0;
      O_NAK <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (tok_ok) begin
            cur_q       <= I_TOK_PIPE;
            cur_setup_q <= I_TOK_SETUP;
            if (I_TOK_SETUP) begin
              if (ign_q[I_TOK_PIPE]) begin
                st_q <= ST_IDLE;
              end else if (lastsetup_q[I_TOK_PIPE]) begin
                st_q <= ST_DROP;
              end else if (flreq_q[I_TOK_PIPE] || st2v_q[I_TOK_PIPE]) begin
                st_q <= ST_IDLE;
              end else begin
                st_q <= ST_RECV;
              end
            end else if (I_STALL) begin
              st_q <= ST_IDLE;
            end else if (en_q[I_TOK_PIPE] && !flreq_q[I_TOK_PIPE]) begin
              st_q <= ST_RECV;
            end else begin
              st_q <= ST_DROP;
            end
          end
        end
        ST_RECV: begin
          if (I_PKT_END) begin
            st_q  <= ST_IDLE;
            O_ACK <= I_PKT_OK && !ovf_q[cur_q];
          end
        end
        ST_DROP: begin
          if (I_PKT_END) begin
            st_q  <= ST_IDLE;
            // Repeated SETUP is acked; disabled OUT is refused.
            O_ACK <= I_PKT_OK && cur_setup_q;
            O_NAK <= I_PKT_OK && !cur_setup_q;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Command registers, flush requests and token history.
  integer p;
  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      en_q        <= 3'b000;
      ign_q       <= 3'b000;
      flreq_q     <= 3'b000;
      wl_q        <= 6'h00;
      lastsetup_q <= 3'b000;
      ovf_q       <= 3'b000;
    end else begin
      for (p = 0; p < 3; p = p + 1) begin
        if (fl[p]) begin
          flreq_q[p] <= 1'b0;
        end
        if (push[p] && !in_rdy[p]) begin
          ovf_q[p] <= 1'b1;
        end
        if (I_WR && hit_c[p]) begin
          ign_q[p]       <= I_WDATA[`USBRX_CMD_IGN];
          wl_q[2*p+1 -: 2] <= I_WDATA[`USBRX_CMD_WL_HI:`USBRX_CMD_WL_LO];
          if (I_WDATA[`USBRX_CMD_EN]) begin
            en_q[p] <= 1'b1;
          end
          if (I_WDATA[`USBRX_CMD_FLUSH]) begin
            flreq_q[p] <= 1'b1;
          end
        end
        if (tok_ok && I_TOK_PIPE == p && !(I_TOK_SETUP && ign_q[p])) begin
          lastsetup_q[p] <= I_TOK_SETUP;
          ovf_q[p]       <= 1'b0;
          // A STALL to OUT disarms; hardware clear wins over a write.
          if (!I_TOK_SETUP && I_STALL) begin
            en_q[p] <= 1'b0;
          end
        end
        if (busy[p] && I_PKT_END && !cur_setup_q) begin
          en_q[p] <= 1'b0;
        end
      end
    end
  end

  // Status copies: a SETUP landing on status with the last bit set goes to the second.
  integer s;
  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      for (s = 0; s < 3; s = s + 1) begin
        stat_q[s]  <= `USBRX_STAT_RST;
        stat2_q[s] <= `USBRX_STAT_RST;
      end
      st2v_q <= 3'b000;
    end else begin
      for (s = 0; s < 3; s = s + 1) begin
        if (I_RD && hit_s[s]) begin
          // Read clears; the second copy then moves up.
          stat_q[s]  <= st2v_q[s] ? stat2_q[s] : `USBRX_STAT_RST;
          st2v_q[s]  <= 1'b0;
        end
        if (busy[s] && I_PKT_END) begin
          if (cur_setup_q && stat_q[s][`USBRX_ST_LAST] &&
              !(I_RD && hit_s[s])) begin
            stat2_q[s] <= {1'b0, 1'b1, I_PKT_TOGGLE, I_PKT_OK, 4'h0};
            st2v_q[s]  <= 1'b1;
          end else begin
            stat_q[s][`USBRX_ST_ERR]    <= !I_PKT_OK;
            stat_q[s][`USBRX_ST_SETUP]  <= cur_setup_q;
            stat_q[s][`USBRX_ST_TOGGLE] <= I_PKT_TOGGLE;
            stat_q[s][`USBRX_ST_LAST]   <= I_PKT_OK;
          end
        end
      end
    end
  end

  // Read data mux; count field saturates at fifteen.
  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= 8'h00;
      for (s = 0; s < 3; s = s + 1) begin
        // Read data shows only in the cycle after a read strobe.
        if (I_RD && hit_d[s]) begin
          O_RDATA <= out_dat[s];
        end
        if (I_RD && hit_s[s]) begin
          O_RDATA <= {stat_q[s][7:4],
                      (cnt[s] > 15) ? `USBRX_CNT_SAT : cnt[s][3:0]};
        end
        if (I_RD && hit_c[s]) begin
          O_RDATA <= {1'b0, wl_q[2*s+1 -: 2], 1'b0, flreq_q[s], ign_q[s],
                      1'b0, en_q[s]};
        end
      end
      if (I_RD && I_ADDR == `USBRX_OFS_FIFO_WARNING_EVENT_REGISTER) begin
        O_RDATA <= {1'b0, O_RX_WARN, 4'h0};
      end
    end
  end
endmodule // usbrx_ctrl

// *** verif/usbrx_ctrl_monitor.sv ***
// Checker of the receive control ports: handshakes, reads and warn flags.
// Assumes it is bound to usbrx_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module usbrx_chk (
  // Clock and reset.
  input logic       I_CLK_SYS,
  input logic       I_RESET_N,
  // Register and packet inputs.
  input logic [5:0] I_ADDR,
  input logic       I_WR,
  input logic       I_RD,
  input logic       I_TOK,
  input logic       I_BYTE_VLD,
  input logic       I_PKT_END,
  input logic       I_PKT_OK,
  // Watched outputs.
  input logic [7:0] O_RDATA,
  input logic       O_ACK,
  input logic       O_NAK,
  input logic [2:0] O_RX_WARN
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  // Any event that may move a fill level, and so a warning flag.
  logic act;
  assign act = I_BYTE_VLD | I_WR | I_RD | I_PKT_END | I_TOK;
  ack_cause_a: assert property (O_ACK |-> $past(I_PKT_END))
    else $error("ACK without a packet end.");
  nak_cause_a: assert property (O_NAK |-> $past(I_PKT_END))
    else $error("NAK without a packet end.");
  ack_single_a: assert property (O_ACK |=> !O_ACK)
    else $error("ACK longer than one cycle.");
  hs_exclusive_a: assert property (!(O_ACK && O_NAK))
    else $error("ACK and NAK together.");
  bad_noack_a: assert property (I_PKT_END && !I_PKT_OK |=> !O_ACK)
    else $error("ACK for a damaged packet.");
  rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("Read data without a read.");
  unmapped_rd_a: assert property (
    I_RD && I_ADDR < 6'h10 |=> O_RDATA == 8'h00)
    else $error("Unmapped read not zero.");
  warn_cause_a: assert property (
    O_RX_WARN != $past(O_RX_WARN) |->
      $past(act) || $past(act, 2) || $past(act, 3))
    else $error("Warning moved without a cause.");
  // Main scenarios reached.
  cover property (O_ACK);
  cover property (O_NAK);
  cover property (O_RX_WARN != 3'b000);
endmodule // usbrx_chk

bind usbrx_ctrl usbrx_chk chk_u (
  .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR),
  .I_WR(I_WR), .I_RD(I_RD), .I_TOK(I_TOK), .I_BYTE_VLD(I_BYTE_VLD),
  .I_PKT_END(I_PKT_END), .I_PKT_OK(I_PKT_OK), .O_RDATA(O_RDATA),
  .O_ACK(O_ACK), .O_NAK(O_NAK), .O_RX_WARN(O_RX_WARN));

// *** verif/usbrx_host.sv ***
// Host model: sends tokens, payload bytes and packet ends to the block.
// Assumes the block samples on the rising edge; this drives on the falling.
`timescale 1ns/1ps
module usbrx_host (
  // Clock of the block.
  input  logic       clk,
  // Packet side toward the block.
  output logic       tok,
  output logic [1:0] pipe,
  output logic       setup,
  output logic       stall,
  output logic       bvld,
  output logic [7:0] bdat,
  output logic       pend,
  output logic       pok,
  output logic       ptgl
);
  initial {tok, pipe, setup, stall, bvld, bdat, pend, pok, ptgl} = '0;
  // One token, n payload bytes from b0 upward, then the packet end.
  task automatic pkt(input [1:0] p, input s, st, input [3:0] n,
                     input [7:0] b0, input ok);
    @(negedge clk);
    tok = 1;
    pipe = p;
    setup = s;
    stall = st;
    @(negedge clk);
    tok = 0;
    // A stalled OUT carries no data packet at all.
    if (!st) begin
      for (int i = 0; i < n; i++) begin
        bvld = 1;
        bdat = b0 + i[7:0];
        @(negedge clk);
      end
      // Idle data shows the inverse, so a stale byte is never mistaken.
      bvld = 0;
      bdat = ~bdat;
      pend = 1;
      pok = ok;
      ptgl = n[0];
      @(negedge clk);
      pend = 0;
      pok = ~ok;
    end
  endtask
endmodule // usbrx_host

// *** verif/usb_receive_endpoint_control_tb_top.sv ***
// Testbench of the receive control: register and packet scenarios.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/1ps
`include "usbrx_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module usb_receive_endpoint_control_tb_top;
  // Clock, reset and register port.
  logic       clk = 0;
  logic       rst_n = 0;
  logic [5:0] addr = 0;
  logic       wr = 0;
  logic       rd = 0;
  logic [7:0] wdata = 0;
  logic [7:0] rdata;
  // Packet side from the host model, answers from the block.
  logic       tok, setup, stall, bvld, pend, pok, ptgl, ack, nak;
  logic [1:0] pipe;
  logic [7:0] bdat;
  logic [2:0] warn;
  // Counters of results, handshakes and cycles.
  int failures = 0, n_tests = 0, acks = 0, naks = 0, cyc = 0;

  always #2 clk = ~clk;

  usbrx_ctrl #(.DEPTH(8), .AW(3)) dut_u (
    .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WR(wr),
    .I_RD(rd), .I_WDATA(wdata), .O_RDATA(rdata), .I_TOK(tok),
    .I_TOK_PIPE(pipe), .I_TOK_SETUP(setup), .I_STALL(stall),
    .I_BYTE_VLD(bvld), .I_BYTE(bdat), .I_PKT_END(pend), .I_PKT_OK(pok),
    .I_PKT_TOGGLE(ptgl), .O_ACK(ack), .O_NAK(nak), .O_RX_WARN(warn));
  usbrx_host host_u (.clk(clk), .tok(tok), .pipe(pipe), .setup(setup),
    .stall(stall), .bvld(bvld), .bdat(bdat), .pend(pend), .pok(pok),
    .ptgl(ptgl));

  // Handshakes are counted, and a hang is cut short after 20000 cycles.
  always @(posedge clk) begin
    cyc++;
    if (ack === 1'b1) acks++;
    if (nak === 1'b1) naks++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Offset of register k (0 data, 1 status, 2 command) of pipe p.
  function automatic [5:0] ofs(input [1:0] p, input [1:0] k);
    ofs = 6'h2D + {1'b0, p, 3'b000} + {4'h0, k};
  endfunction

  task automatic wr_reg(input [5:0] a, input [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask

  // Read data is taken in the cycle after the strobe, when it stands.
  task automatic rd_reg(input [5:0] a, output [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    d = rdata;
  endtask

  task automatic exp_rd(input [5:0] a, input [7:0] m, input [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    `CHK(d & m, e)
  endtask

  // One packet, then the ACK and NAK counts it produced are compared.
  task automatic send(input [1:0] p, input s, st, input [3:0] n,
                      input [7:0] b, input ok, input int ea, en);
    int a0;
    int n0;
    a0 = acks;
    n0 = naks;
    host_u.pkt(p, s, st, n, b, ok);
    repeat (2) @(negedge clk);
    `CHK(acks - a0, ea)
    `CHK(naks - n0, en)
  endtask

  // Reset values of every pipe, and an unmapped address.
  task automatic t_reset();
    for (int p = 0; p < 3; p++) begin
      exp_rd(ofs(p, 1), 8'hFF, 8'h00);
      exp_rd(ofs(p, 2), 8'hFF, 8'h00);
    end
    wr_reg(6'h01, 8'hFF);
    exp_rd(6'h00, 8'hFF, 8'h00);
  endtask

  // Disabled OUT is refused, a stall disarms, an armed OUT lands whole.
  task automatic t_enable();
    send(0, 0, 0, 3, 8'hA0, 1, 0, 1);
    wr_reg(ofs(0, 2), 8'h01);
    send(0, 0, 1, 0, 8'h00, 1, 0, 0);
    exp_rd(ofs(0, 2), 8'h01, 8'h00);
    wr_reg(ofs(0, 2), 8'h01);
    send(0, 0, 0, 3, 8'h51, 1, 1, 0);
    exp_rd(ofs(0, 2), 8'h01, 8'h00);
    exp_rd(ofs(0, 1), 8'hFF, 8'h33);
    for (int i = 0; i < 3; i++) exp_rd(ofs(0, 0), 8'hFF, 8'h51 + i);
    exp_rd(ofs(0, 1), 8'hFF, 8'h00);
  endtask

  // SETUP lands while disarmed; a second one is acked but dropped.
  task automatic t_setup();
    send(1, 1, 0, 2, 8'h10, 1, 1, 0);
    send(1, 1, 0, 3, 8'h20, 1, 1, 0);
    exp_rd(ofs(1, 1), 8'h4F, 8'h42);
    exp_rd(ofs(1, 0), 8'hFF, 8'h10);
    exp_rd(ofs(1, 0), 8'hFF, 8'h11);
  endtask

  // Ignored SETUP, then a damaged OUT flagged and flushed away.
  task automatic t_ignore();
    wr_reg(ofs(2, 2), 8'h04);
    send(2, 1, 0, 2, 8'h30, 1, 0, 0);
    exp_rd(ofs(2, 1), 8'hFF, 8'h00);
    wr_reg(ofs(2, 2), 8'h01);
    send(2, 0, 0, 2, 8'h40, 0, 0, 0);
    exp_rd(ofs(2, 1), 8'h80, 8'h80);
    wr_reg(ofs(2, 2), 8'h08);
    repeat (3) @(negedge clk);
    exp_rd(ofs(2, 1), 8'h0F, 8'h00);
  endtask

  // A flush during reception waits for the end, then empties the pipe.
  task automatic t_flush();
    int a0;
    a0 = acks;
    wr_reg(ofs(0, 2), 8'h01);
    fork
      host_u.pkt(0, 0, 0, 6, 8'h60, 1);
      begin
        repeat (3) @(negedge clk);
        wr_reg(ofs(0, 2), 8'h09);
      end
    join
    repeat (4) @(negedge clk);
    `CHK(acks - a0, 1)
    exp_rd(ofs(0, 2), 8'h08, 8'h00);
    exp_rd(ofs(0, 1), 8'h0F, 8'h00);
    wr_reg(ofs(0, 2), 8'h01);
    send(0, 0, 0, 1, 8'h77, 1, 1, 0);
    exp_rd(ofs(0, 0), 8'hFF, 8'h77);
  endtask

  // Every warning code against free bytes of the 8-deep FIFO.
  task automatic t_warn();
    int wl[5] = '{1, 1, 2, 3, 0};
    int nb[5] = '{3, 4, 0, 0, 8};
    logic w[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      wr_reg(ofs(1, 2), {1'b0, wl[i][1:0], 5'h08});
      repeat (2) @(negedge clk);
      wr_reg(ofs(1, 2), {1'b0, wl[i][1:0], 5'h01});
      send(1, 0, 0, nb[i][3:0], 8'h00, 1, 1, 0);
      repeat (2) @(negedge clk);
      `CHK(warn[1], w[i])
      rd_reg(`USBRX_OFS_FIFO_WARNING_EVENT_REGISTER, d);
      `CHK(d[5], w[i])
    end
    wr_reg(ofs(1, 2), 8'h08);
  endtask

  // A zero-length OUT then a SETUP: two status reads in that order.
  task automatic t_copies();
    logic [7:0] d;
    wr_reg(ofs(2, 2), 8'h01);
    send(2, 0, 0, 0, 8'h00, 1, 1, 0);
    send(2, 1, 0, 2, 8'h90, 1, 1, 0);
    exp_rd(ofs(2, 1), 8'h50, 8'h10);
    rd_reg(ofs(2, 1), d);
    `CHK(d[6], 1'b1)
  endtask

  // Reset for 20 cycles, leave room after release, then run all.
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    t_reset();
    t_enable();
    t_setup();
    t_ignore();
    t_flush();
    t_warn();
    t_copies();
    give_verdict();
  end
endmodule // usb_receive_endpoint_control_tb_top
